// [verilog/scw_decode.sv]
// Synthesizer control word decoder: serial load, field decode and test pin
`default_nettype none
`timescale 1ns/1ps

//
// Behaviour
// - Select 0 hi-Z, 1 high, 2 low
// - Selects 3-5 drive combined, main, aux lock
// - Selects 12-15 drive halved divider outputs
// - Reference mode bit picks single or differential
// - Doubler bit zero bypasses reference doubler
// - Main divider write powers main or both
// - Mode field sets modulator order four/two/three
// - Mode field one disables the modulator
// - Width bit picks 12-bit or 22-bit modulus
// - Aux polarity bit one means positive
// - Main polarity bit one means positive
// - Pump disable bit puts pump hi-Z
// - Auto power up overrides pump hi-Z
// - Numerator extension used only in wide mode
// - Denominator extension used only in wide mode
module scw_decode
    import scw_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    input  wire logic                    ce,
    input  wire logic                    ser_clk,
    input  wire logic                    ser_data,
    input  wire logic                    ser_load,
    input  wire logic [LOWER_WIDTH-1:0]  numerator_lower_bits,
    input  wire logic [LOWER_WIDTH-1:0]  denominator_lower_bits,
    input  wire logic                    main_lock_digital,
    input  wire logic                    aux_lock_digital,
    input  wire logic                    aux_ref_div_out,
    input  wire logic                    aux_fb_div_out,
    input  wire logic                    main_ref_div_out,
    input  wire logic                    main_fb_div_out,
    output logic                         test_lock_pin_out,
    output logic                         test_lock_pin_oe,
    output logic                         ref_differential_mode,
    output logic                         ref_doubler_enable,
    output logic                         modulator_enable,
    output logic [2:0]                   modulator_order,
    output logic                         modulus_wide,
    output logic                         aux_pd_polarity,
    output logic                         main_pd_polarity,
    output logic                         aux_pump_hiz,
    output logic                         main_pump_hiz,
    output logic                         aux_power_up,
    output logic                         main_power_up,
    output logic [FRAC_WIDTH-1:0]        fraction_numerator,
    output logic [FRAC_WIDTH-1:0]        fraction_denominator
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and link shifter
    logic [SYNC_STAGES-1:0]  rst_pipe;
    logic                    rst_sync_b;
    logic [WORD_WIDTH-1:0]   ser_word;
    logic                    load_rise;
    logic [CTRL_WIDTH-1:0]   word_ctrl;
    logic [DIV_COUNT-1:0]    div_in;
    logic [1:0]              auto_power_up_select_hit;
    scw_state_type           st;
    scw_state_type           next_st;

    // Assert at once, release through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= '0;
        end else begin
            rst_pipe <= {rst_pipe[SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe[SYNC_STAGES-1];

    scw_shifter u_shifter (
        .ser_clk  (ser_clk),
        .rst_b    (rst_sync_b),
        .ser_data (ser_data),
        .ser_load (ser_load),
        .ser_word (ser_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    // Reserved code falls to no power up
    function automatic logic [1:0] auto_power_up_select_targets(input logic [1:0] code);  // {aux, main}
        unique case (code)
            AUTO_POWER_UP_SELECT_MAIN: auto_power_up_select_targets = 2'b01;
            AUTO_POWER_UP_SELECT_BOTH: auto_power_up_select_targets = 2'b11;
            default:   auto_power_up_select_targets = 2'b00;
        endcase
    endfunction

    function automatic logic [2:0] order_of(input logic [1:0] code);
        unique case (code)
            FM_ORDER4: order_of = ORDER_FOUR;
            FM_ORDER2: order_of = ORDER_TWO;
            FM_ORDER3: order_of = ORDER_THREE;
            FM_OFF:    order_of = ORDER_NONE;
        endcase
    endfunction

    // Word is quiet while the strobe is high, so the sampled copy is stable
    assign load_rise = st.le_sync & ~st.le_prev;
    assign word_ctrl = ser_word[CTRL_LSB +: CTRL_WIDTH];
    assign div_in    = {main_fb_div_out, main_ref_div_out, aux_fb_div_out, aux_ref_div_out};
    // Power-up targets of the stored code, {aux, main}
    assign auto_power_up_select_hit  = auto_power_up_select_targets(st.auto_power_up_select);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        next_st.le_meta       = ser_load;
        next_st.le_sync       = st.le_meta;
        next_st.le_prev       = st.le_sync;
        next_st.main_power_up = 1'b0;
        next_st.aux_power_up  = 1'b0;

        // Fields change only on a latched, addressed word
        if (load_rise) begin
            if (word_ctrl == CTRL_PLL_CONTROL) begin
                next_st.test_pin_select        = ser_word[PLL_MUX_LSB +: 4];
                next_st.ref_diff               = ser_word[PLL_REF_DIFF_BIT];
                next_st.ref_doubler_enable     = ser_word[PLL_DOUBLER_BIT];
                next_st.auto_power_up_select   = ser_word[PLL_AUTO_POWER_UP_SELECT_LSB +: 2];
                next_st.modulator_order_select = ser_word[PLL_FM_LSB +: 2];
                next_st.modulus_width_select   = ser_word[PLL_FDM_BIT];
                next_st.aux_pd_polarity        = ser_word[PLL_AUX_POL_BIT];
                next_st.aux_pump_hiz           = ser_word[PLL_AUX_HIZ_BIT];
                next_st.main_pd_polarity       = ser_word[PLL_MAIN_POL_BIT];
                next_st.main_pump_hiz          = ser_word[PLL_MAIN_HIZ_BIT];
                // A fresh pump request cancels an earlier override
                next_st.main_override          = 1'b0;
                next_st.aux_override           = 1'b0;
            end else if (word_ctrl == CTRL_FRACTION) begin
                next_st.numerator_upper_bits   = ser_word[FRAC_NUM_LSB +: EXT_WIDTH];
                next_st.denominator_upper_bits = ser_word[FRAC_DEN_LSB +: EXT_WIDTH];
            end else if (ser_word[MAIN_DIV_BIT] == MAIN_DIV_VALUE) begin
                next_st.main_power_up = auto_power_up_select_hit[0];
                next_st.aux_power_up  = auto_power_up_select_hit[1];
                next_st.main_override = st.main_override | auto_power_up_select_hit[0];
                next_st.aux_override  = st.aux_override | auto_power_up_select_hit[1];
            end
        end

        // Halve each divider output by toggling on its rising edge
        for (int i = 0; i < DIV_COUNT; i++) begin
            next_st.div_prev[i] = div_in[i];
            if (div_in[i] && !st.div_prev[i]) begin
                next_st.div_half[i] = ~st.div_half[i];
            end
        end

        // Test pin; analog lock codes stay released as that circuit is absent
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = 1'b0;
        unique case (st.test_pin_select)
            SEL_HIZ:          next_st.pin_oe  = 1'b0;
            SEL_HIGH:         next_st.pin_out = 1'b1;
            SEL_LOW:          next_st.pin_out = 1'b0;
            SEL_LOCK_BOTH:    next_st.pin_out = main_lock_digital & aux_lock_digital;
            SEL_LOCK_MAIN:    next_st.pin_out = main_lock_digital;
            SEL_LOCK_AUX:     next_st.pin_out = aux_lock_digital;
            SEL_AUX_REF_DIV:  next_st.pin_out = st.div_half[DIV_AUX_REF];
            SEL_AUX_FB_DIV:   next_st.pin_out = st.div_half[DIV_AUX_FB];
            SEL_MAIN_REF_DIV: next_st.pin_out = st.div_half[DIV_MAIN_REF];
            SEL_MAIN_FB_DIV:  next_st.pin_out = st.div_half[DIV_MAIN_FB];
            default:          next_st.pin_oe  = 1'b0;
        endcase

        // Extensions count only in wide mode
        next_st.numerator   = {st.modulus_width_select ? st.numerator_upper_bits : 10'h000,
                               numerator_lower_bits};
        next_st.denominator = {st.modulus_width_select ? st.denominator_upper_bits : 10'h000,
                               denominator_lower_bits};
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; clock enable freezes everything
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= SCW_STATE_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign test_lock_pin_out     = st.pin_out;
    assign test_lock_pin_oe      = st.pin_oe;
    assign ref_differential_mode = st.ref_diff;
    assign ref_doubler_enable    = st.ref_doubler_enable;
    assign modulator_enable      = (st.modulator_order_select != FM_OFF);
    assign modulator_order       = order_of(st.modulator_order_select);
    assign modulus_wide          = st.modulus_width_select;
    assign aux_pd_polarity       = st.aux_pd_polarity;
    assign main_pd_polarity      = st.main_pd_polarity;
    // Power-up wins over the pump disable bit
    assign aux_pump_hiz          = st.aux_pump_hiz & ~st.aux_override;
    assign main_pump_hiz         = st.main_pump_hiz & ~st.main_override;
    assign aux_power_up          = st.aux_power_up;
    assign main_power_up         = st.main_power_up;
    assign fraction_numerator    = st.numerator;
    assign fraction_denominator  = st.denominator;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_pin_fixed;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(st.test_pin_select) == SEL_HIGH |-> test_lock_pin_oe && test_lock_pin_out;
    endproperty
    a_pin_fixed: assert property (p_pin_fixed) else $error("test pin not driven high");

    property p_pin_lock;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(st.test_pin_select) == SEL_LOCK_MAIN |-> test_lock_pin_out == $past(main_lock_digital);
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("test pin does not follow main lock");

    property p_pin_div;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(st.test_pin_select) == SEL_MAIN_FB_DIV |->
            test_lock_pin_oe && test_lock_pin_out == $past(st.div_half[DIV_MAIN_FB]);
    endproperty
    a_pin_div: assert property (p_pin_div) else $error("test pin does not show halved divider");

    property p_power_main;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        main_power_up |-> $past(load_rise) && $past(ser_word[MAIN_DIV_BIT]) == MAIN_DIV_VALUE &&
            ($past(st.auto_power_up_select) == AUTO_POWER_UP_SELECT_MAIN || $past(st.auto_power_up_select) == AUTO_POWER_UP_SELECT_BOTH);
    endproperty
    a_power_main: assert property (p_power_main) else $error("main power up without cause");

    property p_power_aux;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        aux_power_up |-> $past(st.auto_power_up_select) == AUTO_POWER_UP_SELECT_BOTH && main_power_up;
    endproperty
    a_power_aux: assert property (p_power_aux) else $error("aux power up on wrong code");

    property p_override;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        main_power_up |-> !main_pump_hiz ##1 (!main_pump_hiz || $past(load_rise));
    endproperty
    a_override: assert property (p_override) else $error("pump hi-Z despite power up");

    property p_order;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(load_rise) && $past(word_ctrl) == CTRL_PLL_CONTROL &&
            $past(ser_word[PLL_FM_LSB +: 2]) == FM_ORDER3 |-> modulator_order == ORDER_THREE && modulator_enable;
    endproperty
    a_order: assert property (p_order) else $error("modulator order not three");

    property p_mod_off;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(load_rise) && $past(word_ctrl) == CTRL_PLL_CONTROL &&
            $past(ser_word[PLL_FM_LSB +: 2]) == FM_OFF |-> !modulator_enable && modulator_order == ORDER_NONE;
    endproperty
    a_mod_off: assert property (p_mod_off) else $error("modulator still enabled");

    property p_narrow;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(rst_sync_b) && !$past(st.modulus_width_select) |->
            fraction_numerator == {10'h000, $past(numerator_lower_bits)};
    endproperty
    a_narrow: assert property (p_narrow) else $error("numerator extension used in narrow mode");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !$past(load_rise) |-> $stable(st.test_pin_select) && $stable(st.modulator_order_select) &&
            $stable(st.numerator_upper_bits);
    endproperty
    a_hold: assert property (p_hold) else $error("field changed without a load");

    // Field checks tie each output to the word that was latched
    property p_ref_mode;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(load_rise) && $past(word_ctrl) == CTRL_PLL_CONTROL |->
            ref_differential_mode == $past(ser_word[PLL_REF_DIFF_BIT]);
    endproperty
    a_ref_mode: assert property (p_ref_mode) else $error("reference mode not taken from word");

    property p_polarity;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(load_rise) && $past(word_ctrl) == CTRL_PLL_CONTROL |->
            aux_pd_polarity == $past(ser_word[PLL_AUX_POL_BIT]) &&
            main_pd_polarity == $past(ser_word[PLL_MAIN_POL_BIT]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity not taken from word");

    // A fresh control word clears any override, so the bits show directly
    property p_pump_hiz;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(load_rise) && $past(word_ctrl) == CTRL_PLL_CONTROL |->
            aux_pump_hiz == $past(ser_word[PLL_AUX_HIZ_BIT]) &&
            main_pump_hiz == $past(ser_word[PLL_MAIN_HIZ_BIT]);
    endproperty
    a_pump_hiz: assert property (p_pump_hiz) else $error("pump hi-Z not taken from word");

    property p_wide_den;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        $past(ce) && $past(rst_sync_b) && $past(st.modulus_width_select) |->
            fraction_denominator == {$past(st.denominator_upper_bits), $past(denominator_lower_bits)};
    endproperty
    a_wide_den: assert property (p_wide_den) else $error("denominator extension lost in wide mode");

endmodule // scw_decode

`default_nettype wire

// [verilog/scw_pkg.sv]
// Package: constants and state types for the synthesizer control word decoder
`default_nettype none

package scw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial word framing
    localparam int          WORD_WIDTH       = 24;
    localparam int          CTRL_LSB         = 0;
    localparam int          CTRL_WIDTH       = 4;
    localparam logic [3:0]  CTRL_PLL_CONTROL = 4'hb;   // Control bits of the PLL control word
    localparam logic [3:0]  CTRL_FRACTION    = 4'hd;   // Control bits of the fraction extension word
    localparam int          MAIN_DIV_BIT     = 0;      // Main divider word recognised by this bit
    localparam logic        MAIN_DIV_VALUE   = 1'b0;
    localparam int          SYNC_STAGES      = 2;

    ////////////////////////////////////////////////////////////////////////////
    // PLL control word field positions
    localparam int          PLL_MUX_LSB      = 4;
    localparam int          PLL_REF_DIFF_BIT = 8;
    localparam int          PLL_DOUBLER_BIT  = 9;
    localparam int          PLL_AUTO_POWER_UP_SELECT_LSB     = 10;
    localparam int          PLL_FM_LSB       = 12;
    localparam int          PLL_FDM_BIT      = 14;
    localparam int          PLL_AUX_POL_BIT  = 15;
    localparam int          PLL_AUX_HIZ_BIT  = 16;
    localparam int          PLL_MAIN_POL_BIT = 17;
    localparam int          PLL_MAIN_HIZ_BIT = 18;

    ////////////////////////////////////////////////////////////////////////////
    // Fraction extension word field positions
    localparam int          EXT_WIDTH        = 10;
    localparam int          LOWER_WIDTH      = 12;
    localparam int          FRAC_WIDTH       = 22;
    localparam int          FRAC_NUM_LSB     = 4;
    localparam int          FRAC_DEN_LSB     = 14;

    ////////////////////////////////////////////////////////////////////////////
    // Test pin select codes
    localparam logic [3:0]  SEL_HIZ          = 4'h0;
    localparam logic [3:0]  SEL_HIGH         = 4'h1;
    localparam logic [3:0]  SEL_LOW          = 4'h2;
    localparam logic [3:0]  SEL_LOCK_BOTH    = 4'h3;
    localparam logic [3:0]  SEL_LOCK_MAIN    = 4'h4;
    localparam logic [3:0]  SEL_LOCK_AUX     = 4'h5;
    localparam logic [3:0]  SEL_AUX_REF_DIV  = 4'hc;
    localparam logic [3:0]  SEL_AUX_FB_DIV   = 4'hd;
    localparam logic [3:0]  SEL_MAIN_REF_DIV = 4'he;
    localparam logic [3:0]  SEL_MAIN_FB_DIV  = 4'hf;

    // Divider index within the halving vector
    localparam int          DIV_AUX_REF      = 0;
    localparam int          DIV_AUX_FB       = 1;
    localparam int          DIV_MAIN_REF     = 2;
    localparam int          DIV_MAIN_FB      = 3;
    localparam int          DIV_COUNT        = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Auto power up and modulator codes
    localparam logic [1:0]  AUTO_POWER_UP_SELECT_NONE        = 2'h0;
    localparam logic [1:0]  AUTO_POWER_UP_SELECT_MAIN        = 2'h1;
    localparam logic [1:0]  AUTO_POWER_UP_SELECT_BOTH        = 2'h2;
    localparam logic [1:0]  FM_ORDER4        = 2'h0;
    localparam logic [1:0]  FM_OFF           = 2'h1;
    localparam logic [1:0]  FM_ORDER2        = 2'h2;
    localparam logic [1:0]  FM_ORDER3        = 2'h3;
    localparam logic [2:0]  ORDER_TWO        = 3'h2;
    localparam logic [2:0]  ORDER_THREE      = 3'h3;
    localparam logic [2:0]  ORDER_FOUR       = 3'h4;
    localparam logic [2:0]  ORDER_NONE       = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // State of the decoder and of the link shifter
    typedef struct packed {
        logic                       le_meta;
        logic                       le_sync;
        logic                       le_prev;
        logic [3:0]                 test_pin_select;
        logic                       ref_diff;
        logic                       ref_doubler_enable;
        logic [1:0]                 auto_power_up_select;
        logic [1:0]                 modulator_order_select;
        logic                       modulus_width_select;
        logic                       aux_pd_polarity;
        logic                       aux_pump_hiz;
        logic                       main_pd_polarity;
        logic                       main_pump_hiz;
        logic [EXT_WIDTH-1:0]       numerator_upper_bits;
        logic [EXT_WIDTH-1:0]       denominator_upper_bits;
        logic                       main_override;
        logic                       aux_override;
        logic                       main_power_up;
        logic                       aux_power_up;
        logic [DIV_COUNT-1:0]       div_prev;
        logic [DIV_COUNT-1:0]       div_half;
        logic                       pin_out;
        logic                       pin_oe;
        logic [FRAC_WIDTH-1:0]      numerator;
        logic [FRAC_WIDTH-1:0]      denominator;
    } scw_state_type;

    typedef struct packed {
        logic [WORD_WIDTH-1:0]      word;
    } scw_shift_state_type;

    localparam scw_state_type       SCW_STATE_RESET = '0;
    localparam scw_shift_state_type SCW_SHIFT_RESET = '0;

endpackage : scw_pkg

`default_nettype wire

// [verilog/scw_shifter.sv]
// Serial link shifter: collects the 24-bit word on the link clock
`default_nettype none
`timescale 1ns/1ps

module scw_shifter
    import scw_pkg::*;
(
    input  wire logic                  ser_clk,
    input  wire logic                  rst_b,
    input  wire logic                  ser_data,
    input  wire logic                  ser_load,
    output logic [WORD_WIDTH-1:0]      ser_word
);

    scw_shift_state_type st;
    scw_shift_state_type next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Shift MSB first; hold while the load strobe is high
    always_comb begin
        next_st = st;
        if (!ser_load) begin
            next_st.word = {st.word[WORD_WIDTH-2:0], ser_data};
        end
    end

    // Link clock may stop between frames, so nothing here counts edges
    always_ff @(posedge ser_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= SCW_SHIFT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ser_word = st.word;

endmodule // scw_shifter

`default_nettype wire

// [sim/scw_host.sv]
// Host controller model: serial programming of the control words
`default_nettype none
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
module scw_host
    import scw_pkg::*;
(
    output logic ser_clk,
    output logic ser_data,
    output logic ser_load
);
    // Link idles with its clock stopped and load low
    initial begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b0;
    end

    // MSB first at 64 ns; load held long past the two-flop sync
    task automatic send(input logic [WORD_WIDTH-1:0] word);
        for (int i = WORD_WIDTH - 1; i >= 0; i--) begin
            ser_data = word[i];
            #32 ser_clk = 1'b1;
            #32 ser_clk = 1'b0;
        end
        ser_data = ~word[0];  // Released line shows no stale bit
        #11 ser_load = 1'b1;
        #60 ser_load = 1'b0;
        #40;
    endtask

    // Values below 4096 carry zero extensions by construction
    task automatic send_fraction(input logic [FRAC_WIDTH-1:0] num, input logic [FRAC_WIDTH-1:0] den);
        send({den[FRAC_WIDTH-1:LOWER_WIDTH], num[FRAC_WIDTH-1:LOWER_WIDTH], CTRL_FRACTION});
    endtask
endmodule // scw_host

`default_nettype wire

// [sim/tb_top.sv]
// Testbench: control word decoder driven through the serial host model
`default_nettype none
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
module tb_top
    import scw_pkg::*;
;
    logic                   sys_clk, rst_b, ser_clk, ser_data, ser_load, seen, ce, cnt_clr;
    logic                   lock_main, lock_aux, pin_out, pin_oe, diff, dbl, mod_en, wide;
    logic                   apol, mpol, ahiz, mhiz, apu, mpu;
    logic [LOWER_WIDTH-1:0] num_lo, den_lo;
    logic [DIV_COUNT-1:0]   div;
    logic [2:0]             order;
    logic [FRAC_WIDTH-1:0]  fnum, fden;
    logic [1:0]             pin_exp [7] = '{2'b00, 2'b11, 2'b10, 2'b10, 2'b11, 2'b10, 2'b00};
    logic [2:0]             ord_exp [4] = '{ORDER_FOUR, ORDER_NONE, ORDER_TWO, ORDER_THREE};
    int                     miscompares = 0, cmp_count = 0, mcnt = 0, acnt = 0;

    scw_host host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));

    scw_decode dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_load(ser_load), .numerator_lower_bits(num_lo), .denominator_lower_bits(den_lo),
        .main_lock_digital(lock_main), .aux_lock_digital(lock_aux), .aux_ref_div_out(div[DIV_AUX_REF]),
        .aux_fb_div_out(div[DIV_AUX_FB]), .main_ref_div_out(div[DIV_MAIN_REF]), .main_fb_div_out(div[DIV_MAIN_FB]),
        .test_lock_pin_out(pin_out), .test_lock_pin_oe(pin_oe), .ref_differential_mode(diff),
        .ref_doubler_enable(dbl), .modulator_enable(mod_en), .modulator_order(order), .modulus_wide(wide),
        .aux_pd_polarity(apol), .main_pd_polarity(mpol), .aux_pump_hiz(ahiz), .main_pump_hiz(mhiz),
        .aux_power_up(apu), .main_power_up(mpu), .fraction_numerator(fnum), .fraction_denominator(fden));

    // 200 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Power-up pulses are one cycle wide, so count them
    always @(posedge sys_clk) begin
        mcnt <= cnt_clr ? 0 : mcnt + int'(mpu === 1'b1);
        acnt <= cnt_clr ? 0 : acnt + int'(apu === 1'b1);
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Control word: both pump disables follow hiz, the mux field follows sel, other fields follow m
    function automatic logic [23:0] pll(input logic [3:0] sel, input logic [1:0] m, input logic hiz);
        return {5'h0, hiz, ~m[1], hiz, m[1], m[0], m, m, m[1], m[0], sel, CTRL_PLL_CONTROL};
    endfunction

    // Main sequence
    initial begin
        rst_b = 1'b0; num_lo = 12'habc; den_lo = 12'h123; lock_main = 1'b1; lock_aux = 1'b0;
        div = '0; ce = 1'b1; cnt_clr = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(pin_oe, 24'h0);
        for (int i = 0; i < 7; i++) begin
            host.send(pll(4'(i), 2'h0, 1'b0));
            repeat (4) @(posedge sys_clk);
            check({pin_oe, pin_out & pin_oe}, pin_exp[i]);
        end
        // Each halved divider must flip the pin once per input rise
        for (int i = 0; i < DIV_COUNT; i++) begin
            host.send(pll(SEL_AUX_REF_DIV + 4'(i), 2'h0, 1'b0));
            repeat (4) @(posedge sys_clk);
            seen = pin_out;
            div[i] <= 1'b1;
            @(posedge sys_clk) div[i] <= 1'b0;
            repeat (3) @(posedge sys_clk);
            check({pin_oe, pin_out}, {1'b1, ~seen});
        end
        for (int m = 0; m < 4; m++) begin
            host.send(pll(SEL_HIZ, 2'(m), 1'b1));
            repeat (4) @(posedge sys_clk);
            check({diff, dbl, wide, apol, mpol}, {m[0], m[1], m[0], m[1], ~m[1]});
            check({mod_en, order}, {m != 1, ord_exp[m]});
            check({ahiz, mhiz}, 2'b11);
            cnt_clr <= 1'b1;
            @(posedge sys_clk) cnt_clr <= 1'b0;
            host.send(24'h000010);
            repeat (4) @(posedge sys_clk);
            check({mcnt[1:0], acnt[1:0], ahiz, mhiz}, {2'(m == 1 || m == 2), 2'(m == 2), m != 2, !(m == 1 || m == 2)});
        end
        host.send_fraction({10'h2a5, num_lo}, {10'h1c3, den_lo});
        repeat (4) @(posedge sys_clk);
        check(fnum, {10'h2a5, num_lo});
        check(fden, {10'h1c3, den_lo});
        host.send(pll(SEL_HIZ, 2'h2, 1'b0));
        repeat (4) @(posedge sys_clk);
        check(fnum, {10'h0, num_lo});
        check(fden, {10'h0, den_lo});
        // Frozen enable drops a whole frame, synchroniser included
        ce <= 1'b0;
        host.send(pll(SEL_HIGH, 2'h3, 1'b0));
        repeat (4) @(posedge sys_clk);
        check({pin_oe, order}, {1'b0, ORDER_TWO});
        ce <= 1'b1;
        // Unknown address must leave every field alone
        host.send(24'hfffff3);
        repeat (4) @(posedge sys_clk);
        check({wide, dbl, order}, {1'b0, 1'b1, ORDER_TWO});
        wrap_up();
    end

    // Hang guard
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
